// ---- rtl/jid_host.sv ----
// JTAG host controller: AXI4-Lite registers and the TAP scan engine
//
// Added by the designer: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none

module jid_host
  import jid_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic jtag_tck,
  output logic jtag_tms,
  output logic jtag_tdi,
  input wire logic jtag_tdo
);

  //============================================================================
  // State
  typedef struct packed {
    logic aw_held;
    logic [ADDR_W-1:0] awaddr;
    logic w_held;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [1:0] op;
    logic [4:0] len;
    logic [31:0] tx;
    logic [31:0] rx;
    logic [15:0] insn;
    jid_path_t path;
    logic busy;
    logic done;
    jid_eng_t eng;
    logic [1:0] cur_op;
    logic [4:0] cur_len;
    logic [5:0] idx;
    logic [7:0] pre_pat;
    logic [2:0] pre_last;
    logic run;
    logic tms;
    logic tdi;
    logic ptms;
    logic ptdi;
    logic [5:0] shift_cnt;
  } jid_host_st_t;

  jid_host_st_t st_r;
  jid_host_st_t st_nxt;

  logic tck_w;
  logic rise_w;
  logic fall_w;
  logic tdo_s;

  //============================================================================
  // Pin input and test clock
  // TDO comes from the device, so it is synchronised before any use
  jid_sync2 u_tdo_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d(jtag_tdo),
    .q(tdo_s)
  );

  // TCK is ours, divided from aclk; edges come back as one-cycle flags
  jid_tck_div u_tck_div (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(st_r.run),
    .tck(tck_w),
    .rise(rise_w),
    .fall(fall_w)
  );

  //============================================================================
  // Next-state logic: bus slave, register file and scan engine
  always_comb
  begin
    logic [2:0] wsel;
    logic [2:0] rsel;
    logic [31:0] ctrl_new;
    logic go;
    logic [5:0] nidx;
    st_nxt = st_r;
    wsel = jid_reg_sel(st_r.awaddr);
    rsel = jid_reg_sel(s_axi_araddr);
    ctrl_new = jid_merge(jid_ctrl_word(st_r.op, st_r.len), st_r.wdata, st_r.wstrb);
    go = 1'b0;
    nidx = st_r.idx + 6'h01;

    // Address and data are caught in either order
    if (s_axi_awvalid && st_r.awready)
    begin
      st_nxt.aw_held = 1'b1;
      st_nxt.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_r.wready)
    begin
      st_nxt.w_held = 1'b1;
      st_nxt.wdata = s_axi_wdata;
      st_nxt.wstrb = s_axi_wstrb;
    end

    // Write executes once both halves are held; busy refuses changes
    if (st_r.aw_held && st_r.w_held && !st_r.bvalid)
    begin
      st_nxt.aw_held = 1'b0;
      st_nxt.w_held = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      if (wsel == SEL_CTRL && !st_r.busy)
      begin
        st_nxt.op = ctrl_new[CTRL_OP_LSB +: 2];
        st_nxt.len = ctrl_new[CTRL_LEN_LSB +: 5];
        go = st_r.wstrb[0] && st_r.wdata[CTRL_GO_BIT];
      end
      if (wsel == SEL_TX && !st_r.busy)
      begin
        st_nxt.tx = jid_merge(st_r.tx, st_r.wdata, st_r.wstrb);
      end
    end
    if (st_r.bvalid && s_axi_bready)
    begin
      st_nxt.bvalid = 1'b0;
    end

    // Reads answer on the edge that takes the address
    if (s_axi_arvalid && st_r.arready)
    begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp = RESP_OKAY;
      case (rsel)
        SEL_CTRL: st_nxt.rdata = jid_ctrl_word(st_r.op, st_r.len);
        SEL_TX: st_nxt.rdata = st_r.tx;
        SEL_RX: st_nxt.rdata = st_r.rx;
        SEL_STAT:
        begin
          st_nxt.rdata = 32'h0000_0000;
          st_nxt.rdata[STAT_BUSY_BIT] = st_r.busy;
          st_nxt.rdata[STAT_DONE_BIT] = st_r.done;
          st_nxt.rdata[STAT_PATH_LSB +: 3] = st_r.path;
          st_nxt.rdata[STAT_INSN_LSB +: 16] = st_r.insn;
        end
        default:
        begin
          st_nxt.rdata = 32'h0000_0000;
          st_nxt.rresp = RESP_SLVERR;
        end
      endcase
    end
    if (st_r.rvalid && s_axi_rready)
    begin
      st_nxt.rvalid = 1'b0;
    end
    st_nxt.awready = !st_nxt.aw_held && !st_nxt.bvalid;
    st_nxt.wready = !st_nxt.w_held && !st_nxt.bvalid;
    st_nxt.arready = !st_nxt.rvalid;

    // Scan engine: TMS/TDI change after falling TCK, device samples on rising
    case (st_r.eng)
      ENG_IDLE:
      begin
        if (go)
        begin
          st_nxt.busy = 1'b1;
          st_nxt.done = 1'b0;
          st_nxt.cur_op = st_nxt.op;
          st_nxt.idx = 6'h00;
          st_nxt.shift_cnt = 6'h00;
          st_nxt.tdi = 1'b0;
          st_nxt.run = 1'b1;
          st_nxt.eng = ENG_PRE;
          // Preamble walks from Run-Test/Idle into the wanted shift state, or for reset through Test-Logic-Reset back to Idle [RULE2]
          case (st_nxt.op)
            OP_INSN:
            begin
              st_nxt.pre_pat = PRE_INSN;
              st_nxt.pre_last = PRE_INSN_LAST;
              st_nxt.cur_len = 5'(INSN_LEN - 1); // Always a full code [RULE3]
            end
            OP_DATA:
            begin
              st_nxt.pre_pat = PRE_DATA;
              st_nxt.pre_last = PRE_DATA_LAST;
              st_nxt.cur_len = st_nxt.len;
            end
            default:
            begin
              st_nxt.pre_pat = PRE_RESET;
              st_nxt.pre_last = PRE_RESET_LAST;
              st_nxt.cur_len = 5'h00;
            end
          endcase
          st_nxt.tms = st_nxt.pre_pat[0];
        end
      end
      ENG_PRE:
      begin
        if (rise_w)
        begin
          if (st_r.idx[2:0] == st_r.pre_last)
          begin
            if (st_r.cur_op == OP_RESET)
            begin
              st_nxt.eng = ENG_STOP;
              st_nxt.run = 1'b0;
            end
            else
            begin
              st_nxt.eng = ENG_SHIFT;
              st_nxt.idx = 6'h00;
              st_nxt.ptms = (st_r.cur_len == 5'h00);
              st_nxt.ptdi = st_r.tx[0];
            end
          end
          else
          begin
            st_nxt.idx = nidx;
            st_nxt.ptms = st_r.pre_pat[nidx[2:0]];
            st_nxt.ptdi = 1'b0;
          end
        end
      end
      ENG_SHIFT:
      begin
        if (rise_w)
        begin
          // TDO is taken on the same rising edge that shifts TDI in [RULE1]
          st_nxt.rx[st_r.idx[4:0]] = tdo_s;
          st_nxt.shift_cnt = st_r.shift_cnt + 6'h01;
          if (st_r.idx[4:0] == st_r.cur_len)
          begin
            // Exit1 reached; Update then Idle follow [RULE2]
            st_nxt.eng = ENG_POST;
            st_nxt.idx = 6'h00;
            st_nxt.ptms = 1'b1;
            st_nxt.ptdi = 1'b0;
          end
          else
          begin
            st_nxt.idx = nidx;
            st_nxt.ptdi = st_r.tx[nidx[4:0]];
            st_nxt.ptms = (nidx[4:0] == st_r.cur_len);
          end
        end
      end
      ENG_POST:
      begin
        if (rise_w)
        begin
          if (st_r.idx == 6'h00)
          begin
            st_nxt.idx = 6'h01;
            st_nxt.ptms = 1'b0;
          end
          else
          begin
            st_nxt.eng = ENG_STOP;
            st_nxt.run = 1'b0;
          end
        end
      end
      ENG_STOP:
      begin
        if (fall_w)
        begin
          st_nxt.eng = ENG_IDLE;
          st_nxt.busy = 1'b0;
          st_nxt.done = 1'b1;
          // Track which register the device now has in its path [RULE4]
          if (st_r.cur_op == OP_INSN)
          begin
            st_nxt.insn = st_r.tx[15:0];
            st_nxt.path = jid_path_of(st_r.tx[15:0]);
          end
          else if (st_r.cur_op == OP_RESET)
          begin
            st_nxt.insn = INSN_RESET;
            st_nxt.path = jid_path_of(INSN_RESET);
          end
        end
      end
      default:
      begin
        st_nxt.eng = ENG_IDLE;
      end
    endcase

    // Pending bit goes to the pins while TCK is low
    if (fall_w && st_r.eng != ENG_STOP && st_r.eng != ENG_IDLE)
    begin
      st_nxt.tms = st_r.ptms;
      st_nxt.tdi = st_r.ptdi;
    end
  end

  //============================================================================
  // State register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_r <= '0;
      st_r.tx <= TX_RESET;
      st_r.insn <= INSN_RESET;
      st_r.path <= jid_path_of(INSN_RESET);
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  //============================================================================
  // Outputs, all from flops
  assign s_axi_awready = st_r.awready;
  assign s_axi_wready = st_r.wready;
  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_arready = st_r.arready;
  assign s_axi_rvalid = st_r.rvalid;
  assign s_axi_rdata = st_r.rdata;
  assign s_axi_rresp = st_r.rresp;
  assign jtag_tck = tck_w;
  assign jtag_tms = st_r.tms;
  assign jtag_tdi = st_r.tdi;

  //============================================================================
  // Assertions
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_launch;
    $rose(st_r.busy) && st_r.run && st_r.eng == ENG_PRE;
  endsequence

  sequence s_insn_end;
    $fell(st_r.busy) && st_r.cur_op == OP_INSN;
  endsequence

  a_tck_idle_low: assert property (st_r.eng == ENG_IDLE |-> !tck_w) // [RULE1]
    else $error("TCK high while idle");
  a_tms_on_low: assert property ($changed(st_r.tms) |-> !tck_w) // [RULE2]
    else $error("TMS changed while TCK high");
  a_scan_bounded: assert property (s_launch |-> ##[40:400] $fell(st_r.busy)) // [RULE2]
    else $error("Scan did not finish in time");
  a_insn_length: assert property (s_insn_end |-> st_r.shift_cnt == 6'(INSN_LEN)) // [RULE3]
    else $error("Instruction scan not 16 bits");
  a_insn_loaded: assert property (s_insn_end |-> st_r.insn == st_r.tx[15:0]) // [RULE3]
    else $error("Instruction shadow not updated");
  a_path_drive: assert property (st_r.insn == INSN_BSCAN_DRIVE |-> st_r.path == PATH_BSCAN_DRIVE) // [RULE4]
    else $error("Wrong path for drive code");
  a_path_sample: assert property (st_r.insn == INSN_BSCAN_SAMPLE |-> st_r.path == PATH_BSCAN_SAMPLE) // [RULE5]
    else $error("Wrong path for sample code");
  a_path_ident: assert property (st_r.insn == INSN_IDENT |-> st_r.path == PATH_IDENT) // [RULE6]
    else $error("Wrong path for ident code");
  a_path_bypass: assert property (st_r.insn == INSN_BYPASS |-> st_r.path == PATH_BYPASS) // [RULE7]
    else $error("Wrong path for bypass code");
  a_path_nvctl: assert property (st_r.insn == INSN_NV_CTL |-> st_r.path == PATH_NV_CTL) // [RULE8]
    else $error("Wrong path for control code");
  a_path_nvdat: assert property (st_r.insn == INSN_NV_DAT |-> st_r.path == PATH_NV_DAT) // [RULE9]
    else $error("Wrong path for data code");
  a_path_nvadr: assert property (st_r.insn == INSN_NV_ADR |-> st_r.path == PATH_NV_ADR) // [RULE10]
    else $error("Wrong path for address code");
  a_path_nvscl: assert property (st_r.insn == INSN_NV_SCL |-> st_r.path == PATH_NV_SCL) // [RULE11]
    else $error("Wrong path for prescaler code");
  a_bresp_hold: assert property (st_r.bvalid && !s_axi_bready |=> st_r.bvalid && $stable(st_r.bresp))
    else $error("Write response dropped early");

endmodule : jid_host

`default_nettype wire

// ---- rtl/jid_pkg.sv ----
// Package for the JTAG host controller: register map, fields, codes, timing
//==============================================================================
// Summary of operation
// RULE1 - Only clock, mode, data in, data out
// RULE2 - Walk the standard TAP states per scan
// RULE3 - Instruction scans are always sixteen bits
// RULE4 - Code 0000 drives pins via boundary chain
// RULE5 - Code 0002 samples pins, preloads latches
// RULE6 - Code 0004 shifts out identification value
// RULE7 - Code FFFF selects one-bit bypass path
// RULE8 - Code 0082 selects memory control register
// RULE9 - Code 0083 selects memory data register
// RULE10 - Code 0084 selects memory address register
// RULE11 - Code 0085 selects memory prescaler register
// RULE12 - Device has boundary, ident, bypass registers
// RULE13 - Device has four memory access registers
// RULE14 - Unknown codes fall back to bypass
`default_nettype none

package jid_pkg;

  //============================================================================
  // Register map
  localparam int ADDR_W = 8;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_TXDATA = 8'h04;
  localparam logic [7:0] REG_RXDATA = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [2:0] SEL_CTRL = 3'h0;
  localparam logic [2:0] SEL_TX = 3'h1;
  localparam logic [2:0] SEL_RX = 3'h2;
  localparam logic [2:0] SEL_STAT = 3'h3;
  localparam logic [2:0] SEL_NONE = 3'h4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  //============================================================================
  // Field positions and reset values
  localparam int CTRL_GO_BIT = 0;
  localparam int CTRL_OP_LSB = 1;
  localparam int CTRL_LEN_LSB = 8;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int STAT_PATH_LSB = 4;
  localparam int STAT_INSN_LSB = 16;
  localparam logic [31:0] TX_RESET = 32'h0000_0000;
  localparam logic [15:0] INSN_RESET = 16'h0000;

  //============================================================================
  // Operations, TMS preambles and the instruction codes
  localparam logic [1:0] OP_RESET = 2'h0;
  localparam logic [1:0] OP_INSN = 2'h1;
  localparam logic [1:0] OP_DATA = 2'h2;
  localparam logic [7:0] PRE_RESET = 8'h1F;
  localparam logic [2:0] PRE_RESET_LAST = 3'h5;
  localparam logic [7:0] PRE_INSN = 8'h03;
  localparam logic [2:0] PRE_INSN_LAST = 3'h3;
  localparam logic [7:0] PRE_DATA = 8'h01;
  localparam logic [2:0] PRE_DATA_LAST = 3'h2;
  localparam int INSN_LEN = 16;
  localparam logic [15:0] INSN_BSCAN_DRIVE = 16'h0000;
  localparam logic [15:0] INSN_BSCAN_SAMPLE = 16'h0002;
  localparam logic [15:0] INSN_IDENT = 16'h0004;
  localparam logic [15:0] INSN_BYPASS = 16'hFFFF;
  localparam logic [15:0] INSN_NV_CTL = 16'h0082;
  localparam logic [15:0] INSN_NV_DAT = 16'h0083;
  localparam logic [15:0] INSN_NV_ADR = 16'h0084;
  localparam logic [15:0] INSN_NV_SCL = 16'h0085;

  //============================================================================
  // Timing: TCK half period in aclk cycles (TCK = 160 ns at 50 MHz)
  localparam int TCK_HALF_CYC = 4;
  localparam logic [2:0] DIV_LAST = 3'(TCK_HALF_CYC - 1);

  //============================================================================
  // Types
  typedef enum logic [2:0] {ENG_IDLE, ENG_PRE, ENG_SHIFT, ENG_POST, ENG_STOP} jid_eng_t;
  typedef enum logic [2:0] {
    PATH_BSCAN_DRIVE, PATH_BSCAN_SAMPLE, PATH_IDENT, PATH_BYPASS,
    PATH_NV_CTL, PATH_NV_DAT, PATH_NV_ADR, PATH_NV_SCL
  } jid_path_t;

  //============================================================================
  // Helpers
  function automatic jid_path_t jid_path_of(input logic [15:0] code);
    case (code)
      INSN_BSCAN_DRIVE: return PATH_BSCAN_DRIVE;
      INSN_BSCAN_SAMPLE: return PATH_BSCAN_SAMPLE;
      INSN_IDENT: return PATH_IDENT;
      INSN_NV_CTL: return PATH_NV_CTL;
      INSN_NV_DAT: return PATH_NV_DAT;
      INSN_NV_ADR: return PATH_NV_ADR;
      INSN_NV_SCL: return PATH_NV_SCL;
      default: return PATH_BYPASS; // Unknown codes see the bypass stage [RULE14]
    endcase
  endfunction : jid_path_of

  function automatic logic [2:0] jid_reg_sel(input logic [ADDR_W-1:0] addr);
    case ({addr[7:2], 2'h0})
      REG_CTRL: return SEL_CTRL;
      REG_TXDATA: return SEL_TX;
      REG_RXDATA: return SEL_RX;
      REG_STATUS: return SEL_STAT;
      default: return SEL_NONE;
    endcase
  endfunction : jid_reg_sel

  function automatic logic [31:0] jid_merge(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
      begin
        res[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return res;
  endfunction : jid_merge

  function automatic logic [31:0] jid_ctrl_word(input logic [1:0] op, input logic [4:0] len);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[CTRL_OP_LSB +: 2] = op;
    w[CTRL_LEN_LSB +: 5] = len;
    return w;
  endfunction : jid_ctrl_word

endpackage : jid_pkg

`default_nettype wire

// ---- rtl/jid_sync2.sv ----
// Two-flop synchroniser for the serial data returned by the device
`timescale 1ns/100ps
`default_nettype none

module jid_sync2
  import jid_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic d,
  output logic q
);

  typedef struct packed {
    logic s1;
    logic s2;
  } jid_sync_st_t;

  jid_sync_st_t st_r;
  jid_sync_st_t st_nxt;

  //============================================================================
  // First stage feeds only the second stage
  always_comb
  begin
    st_nxt.s1 = d;
    st_nxt.s2 = st_r.s1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign q = st_r.s2;

endmodule : jid_sync2

`default_nettype wire

// ---- rtl/jid_tck_div.sv ----
// Test clock divider: makes TCK from aclk and flags its edges
`timescale 1ns/100ps
`default_nettype none

module jid_tck_div
  import jid_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic run,
  output logic tck,
  output logic rise,
  output logic fall
);

  typedef struct packed {
    logic [2:0] cnt;
    logic tck;
    logic rise;
    logic fall;
  } jid_div_st_t;

  jid_div_st_t st_r;
  jid_div_st_t st_nxt;

  //============================================================================
  // A high phase is always finished, so TCK never stops high or short
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.rise = 1'b0;
    st_nxt.fall = 1'b0;
    if (run || st_r.tck)
    begin
      if (st_r.cnt == DIV_LAST)
      begin
        st_nxt.cnt = 3'h0;
        st_nxt.tck = ~st_r.tck;
        st_nxt.rise = ~st_r.tck;
        st_nxt.fall = st_r.tck;
      end
      else
      begin
        st_nxt.cnt = st_r.cnt + 3'h1;
      end
    end
    else
    begin
      st_nxt.cnt = 3'h0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // Outputs come straight from the state flops
  assign tck = st_r.tck;
  assign rise = st_r.rise;
  assign fall = st_r.fall;

endmodule : jid_tck_div

`default_nettype wire

// ---- testbench/jid_dev_model.sv ----
// Behavioural device model: TAP states, instruction and data registers
`timescale 1ns/100ps
`default_nettype none

module jid_dev_model
  import jid_pkg::*;
#(
  parameter logic [31:0] ID_VAL = 32'h1234_5A5B, // Arbitrary value
  parameter logic [7:0] PIN_VAL = 8'hA6
)
(
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo
);
  //============================================================================
  // State
  // Next-state tables, one nibble per TAP state, TMS high and TMS low
  localparam logic [63:0] T1 = 64'h2FEF_CC02_8785_5920;
  localparam logic [63:0] T0 = 64'h1BDD_BBA1_4664_4311;
  logic [3:0] st = 4'h0;
  logic [15:0] ir = INSN_RESET;
  logic [15:0] irs = 16'h0000;
  logic [31:0] dr = 32'h0000_0000;
  logic [7:0] nv [4] = '{default: 8'h00};
  logic [1:0] idx;
  int w;
  initial tdo = 1'b0;
  assign idx = 2'(ir[2:0] - 3'h2);

  //============================================================================
  // Selected data register length; unknown codes get the one-bit stage
  always_comb
  begin
    case (ir)
      INSN_IDENT: w = 32;
      INSN_BSCAN_DRIVE, INSN_BSCAN_SAMPLE: w = 8;
      INSN_NV_CTL, INSN_NV_DAT, INSN_NV_ADR, INSN_NV_SCL: w = 8;
      default: w = 1;
    endcase
  end

  // Capture, shift and update at the rising test clock
  always @(posedge tck)
  begin
    case (st)
      4'h0: ir <= INSN_RESET;
      4'h3: dr <= (ir == INSN_IDENT) ? ID_VAL : (w == 1) ? 32'h0 : ir[7] ? 32'(nv[idx]) : 32'(PIN_VAL);
      4'h4: dr <= (dr >> 1) | (32'(tdi) << (w - 1));
      4'h8: if (ir[7] && w == 8) nv[idx] <= dr[7:0];
      4'hA: irs <= 16'h0001;
      4'hB: irs <= {tdi, irs[15:1]};
      4'hF: ir <= irs;
      default: ;
    endcase
    st <= tms ? T1[4*st +: 4] : T0[4*st +: 4];
  end

  // Out of shift the line toggles, so stale data cannot pass as a match
  always @(negedge tck)
    tdo <= (st == 4'h4) ? dr[0] : (st == 4'hB) ? irs[0] : ~tdo;
endmodule : jid_dev_model

`default_nettype wire

// ---- testbench/jtag_instruction_decode_test.sv ----
// Self-checking bench for the JTAG host controller against the device model
`timescale 1ns/100ps
`default_nettype none

module jtag_instruction_decode_test
  import jid_pkg::*;
;
  localparam logic [31:0] ID_VAL = 32'hC3A5_0F01; // Arbitrary value
  localparam logic [7:0] PIN_VAL = 8'h5C;
  logic aclk = 1'b0, aresetn = 1'b0, awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0;
  logic awr, wr, bv, arr, rv, tck, tms, tdi, tdo;
  logic [1:0] br, rr;
  logic [31:0] rd;
  logic [31:0] seed = 32'h0042;
  logic [15:0] codes [9] = '{16'h0000, 16'h0002, 16'h0004, 16'hFFFF, 16'h0082,
                             16'h0083, 16'h0084, 16'h0085, 16'h0011};
  logic [7:0] nvx [4] = '{default: 8'h00};
  int error_cnt = 0, n_compared = 0;

  //============================================================================
  // Clock, design and device
  always #10 aclk = ~aclk;
  jid_host DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_awaddr(awa), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hF), .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_bresp(br),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_rvalid(rv),
    .s_axi_rready(rre), .s_axi_rdata(rd), .s_axi_rresp(rr),
    .jtag_tck(tck), .jtag_tms(tms), .jtag_tdi(tdi), .jtag_tdo(tdo));
  jid_dev_model #(.ID_VAL(ID_VAL), .PIN_VAL(PIN_VAL)) dev (.tck(tck), .tms(tms), .tdi(tdi),
    .tdo(tdo));

  //============================================================================
  // Helpers
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  // Expected path code for an instruction; anything unlisted is bypass
  function automatic logic [2:0] path_exp(input logic [15:0] c);
    case (c)
      INSN_BSCAN_DRIVE: return 3'h0;
      INSN_BSCAN_SAMPLE: return 3'h1;
      INSN_IDENT: return 3'h2;
      INSN_NV_CTL: return 3'h4;
      INSN_NV_DAT: return 3'h5;
      INSN_NV_ADR: return 3'h6;
      INSN_NV_SCL: return 3'h7;
      default: return 3'h3;
    endcase
  endfunction : path_exp

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    n_compared++;
    if (got !== ex)
    begin
      $display("BAD %s expected %h seen %h", nm, ex, got);
      error_cnt++;
    end
  endtask : chk

  task automatic print_verdict();
    if (error_cnt == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : print_verdict

  // Write: address and data offered together, each dropped once taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    awv <= 1'b1;
    awa <= a;
    wv <= 1'b1;
    wd <= d;
    bre <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awr === 1'b1) awv <= 1'b0;
      if (wr === 1'b1) wv <= 1'b0;
    end
    while (bv !== 1'b1); // Only the watchdog ends a stalled wait
    r = br;
    bre <= 1'b0;
  endtask : axw

  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    arv <= 1'b1;
    ara <= a;
    rre <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arr === 1'b1) arv <= 1'b0;
    end
    while (rv !== 1'b1);
    d = rd;
    r = rr;
    rre <= 1'b0;
  endtask : axr

  // One scan: load data, start, poll until done, fetch captured bits
  task automatic scan(input logic [1:0] op, input int len, input logic [31:0] tx,
                      output logic [31:0] rx, output logic [31:0] st);
    logic [1:0] r;
    axw(REG_TXDATA, tx, r);
    axw(REG_CTRL, {19'h0, 5'(len - 1), 5'h0, op, 1'b1}, r);
    do
    begin
      axr(REG_STATUS, st, r);
    end
    while (st[1:0] !== 2'b10);
    axr(REG_RXDATA, rx, r);
  endtask : scan

  //============================================================================
  // Watchdog: the whole run needs roughly 7000 cycles
  initial
  begin
    repeat (40000) @(posedge aclk);
    error_cnt++;
    print_verdict();
  end

  //============================================================================
  // Main sequence
  initial
  begin
    logic [31:0] d, st, tx, ex;
    logic [1:0] r;
    int len, idx;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    // Reset values, then one address past the map
    for (int a = 0; a < 20; a += 4)
    begin
      axr(8'(a), d, r);
      chk("rdata", 32'h0, d);
      chk("rresp", (a == 16) ? 32'(RESP_SLVERR) : 32'(RESP_OKAY), 32'(r));
    end
    axw(8'h10, 32'h1, r);
    chk("bresp", 32'(RESP_SLVERR), 32'(r));
    scan(OP_RESET, 1, 32'h0, d, st);
    chk("code after reset", 32'(INSN_RESET), 32'(st[31:16]));
    // Every listed code twice, the unknown one redrawn each pass, so memory registers show what the first pass stored
    for (int p = 0; p < 2; p++)
    begin
      for (int k = 0; k < 9; k++)
      begin
        tx = rnd();
        if (k == 8) codes[8] = {tx[15:8], 8'h11};
        scan(OP_INSN, INSN_LEN, tx ^ 32'(tx[15:0] ^ codes[k]), d, st);
        chk("ir capture", 32'h0001, 32'(d[15:0]));
        chk("code", 32'(codes[k]), 32'(st[31:16]));
        chk("path", 32'(path_exp(codes[k])), 32'(st[6:4]));
        tx = rnd();
        idx = int'(codes[k][2:0]) - 2;
        len = (codes[k] == INSN_IDENT || path_exp(codes[k]) == 3'h3) ? 32 : 8;
        if (codes[k] == INSN_IDENT) ex = ID_VAL;
        else if (len == 32) ex = {tx[30:0], 1'b0};
        else if (codes[k][7]) ex = 32'(nvx[idx]);
        else ex = 32'(PIN_VAL);
        scan(OP_DATA, len, tx, d, st);
        chk("data capture", ex, (len == 32) ? d : 32'(d[7:0]));
        if (codes[k][7] && len == 8) nvx[idx] = tx[7:0];
      end
    end
    print_verdict();
  end
endmodule : jtag_instruction_decode_test

`default_nettype wire
